// [core/sfa_pkg.sv]
// constants and types shared by the supply fault action block
package sfa_pkg;
	// command code of the fault action word
	localparam logic [7:0] CFG_OFFSET = 8'hd9;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// writable positions; everything else reads as zero
	localparam logic [31:0] CFG_WMASK = 32'h0707_f7ff;
	// field positions
	localparam int OBEY_LSB = 24;
	localparam int DRIVE_LSB = 16;
	localparam int LOG_BIT = 15;
	localparam int SCOPE_BIT = 14;
	localparam int FILT_LSB = 12;
	localparam int ALARM_LSB = 8;
	localparam int OT_LSB = 6;
	localparam int PUT_LSB = 4;
	localparam int UV_LSB = 2;
	localparam int OVOC_LSB = 0;
	// two-bit action codes
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LATCH = 2'h1;
	localparam logic [1:0] ACT_RETRY = 2'h2;
	localparam logic [1:0] ACT_CONT = 2'h3;
	// event index inside status, log and code vectors
	localparam int EV_OVOC = 0;
	localparam int EV_UV = 1;
	localparam int EV_PUT = 2;
	localparam int EV_OT = 3;
	localparam int NUM_EV = 4;
	// pages from here up ignore the power-up timeout code
	localparam int HIGH_PAGE_FIRST = 12;
	localparam int NUM_LINES = 3;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	// channel action state, one-hot
	typedef enum logic [2:0] {
		SFA_RUN = 3'b001,
		SFA_RETRY = 3'b010,
		SFA_LATCH = 3'b100
	} sfa_state_t;
endpackage : sfa_pkg

// [core/sfa_excursion_filter.sv]
// excursion persistence filter, counts whole millisecond ticks
`timescale 1ns/10ps
`default_nettype none
module sfa_excursion_filter (
	input wire logic clock,
	input wire logic rst,
	input wire logic ms_tick,
	input wire logic [1:0] filt_code,
	input wire logic excursion,
	output logic declared
);
	typedef struct packed {
		logic [2:0] cnt;
		logic decl;
	} sfa_filt_t;
	sfa_filt_t q, d;

	// restart on any break; the first tick may be partial, so the
	// declared time lands between n-1 and n milliseconds
	always_comb begin
		d = q;
		if (!excursion) begin
			d.cnt = 3'h0;
			d.decl = 1'b0;
		end else if (filt_code == 2'h0) begin
			d.decl = 1'b1;
		end else if (!q.decl && ms_tick) begin
			d.cnt = q.cnt + 3'h1;
			if (d.cnt >= {1'b0, filt_code} + 3'h1) begin
				d.decl = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign declared = q.decl;

	a_break_clears: assert property (@(posedge clock) disable iff (rst)
		!excursion |=> !declared) else $error("filter kept fault after break");
	a_immediate_code: assert property (@(posedge clock) disable iff (rst)
		excursion && filt_code == 2'h0 |=> declared) else $error("immediate code delayed");
	a_no_early_decl: assert property (@(posedge clock) disable iff (rst)
		$rose(declared) && $past(filt_code) != 2'h0 |-> $past(ms_tick))
		else $error("filtered fault declared off tick");
endmodule : sfa_excursion_filter
`default_nettype wire

// [core/sfa_fault_action.sv]
// per-page fault action logic driven by the fault action word
// Operation
// - reserved bits 31:27, 23:19 and 11 always read zero
// - bits 26:24 enable obeying shared fault lines 2..0
// - bits 18:16 permit driving shared fault lines 2..0
// - bit 15 enables writing qualifying faults to persistent log
// - bit 14 picks local or shared scope
// - bits 13:12 pick persistence: immediate, 2, 3 or 4 ms
// - temperature and sequencing faults bypass the persistence filter
// - bits 10:8 pick alarm source; codes 3, 5 and 7 include warnings
// - action codes at 7:6 temp, 5:4 timeout, 3:2 under, 1:0 over
// - lowest code acts on overvoltage or overcurrent per measurement mode
// - current channels ignore undervoltage and power-up timeout codes
// - pages 12 to 15 ignore the power-up timeout code
// - enabled temperature sensor faults are ORed into one fault
// - code 11 sets status, logs if enabled, keeps running
// - retry drives lines, waits delay, releases only when fault-free
// - undervoltage does not count against fault-free for retry release
// - latch off drives permitted lines, sets status, logs if enabled
// - code 00 only sets status, no shutdown and no log
// - alert asserts when enabled and a status bit newly sets
// - status bits latch once any fault that is not ignored occurs, whatever its code
// - code 01 is latch off, code 10 is retry
// - shared channel holds supply off while an obeyed line asserts
`timescale 1ns/10ps
`default_nettype none
module sfa_fault_action #(
	parameter int PAGE = 0,
	parameter int NUM_TEMP = 5,
	parameter int MS_CYCLES = sfa_pkg::MS_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_cmd,
	input wire logic [31:0] cfg_wr_data,
	output logic [31:0] cfg_rd_data,
	input wire logic measure_current,
	input wire logic over_excursion,
	input wire logic over_warn_excursion,
	input wire logic under_excursion,
	input wire logic under_warn_excursion,
	input wire logic powerup_timeout,
	input wire logic [NUM_TEMP-1:0] temp_fault,
	input wire logic [NUM_TEMP-1:0] temp_sensor_en,
	input wire logic [15:0] restart_delay_ms,
	input wire logic master_on,
	input wire logic clear_faults,
	input wire logic alert_en,
	input wire logic [2:0] shared_fault_line_in,
	output logic [2:0] shared_fault_line_out,
	output logic [2:0] shared_fault_line_oe,
	output logic supply_enable_out,
	output logic [3:0] fault_status,
	output logic alert_out,
	output logic log_req,
	output logic [3:0] log_kind,
	output logic alarm_out
);
	typedef struct packed {
		logic [31:0] cfg;
		logic [2:0] line_s1;
		logic [2:0] line_s2;
		logic [31:0] div;
		logic tick;
		sfa_pkg::sfa_state_t state;
		logic [15:0] retry_cnt;
		logic [2:0] drive;
		logic [3:0] status;
		logic [3:0] logged;
		logic [3:0] prev;
		logic master_prev;
		logic alert;
		logic log_req;
		logic [3:0] log_kind;
		logic alarm;
		logic supply_en;
	} sfa_main_t;
	sfa_main_t q, d;

	logic ovoc_decl;
	logic ovoc_warn_decl;
	logic uv_decl;
	logic uv_warn_decl;
	logic ot_now;
	logic [3:0] present;
	logic [3:0] ignored;
	logic [7:0] codes;
	logic [3:0] acting;
	logic global_scope;
	logic [2:0] obeyed;
	logic [2:0] permit;
	logic line_hold;

	// config field views
	assign global_scope = q.cfg[sfa_pkg::SCOPE_BIT];
	assign obeyed = q.cfg[sfa_pkg::OBEY_LSB +: 3];
	assign permit = q.cfg[sfa_pkg::DRIVE_LSB +: 3];
	// codes packed in event order: over, under, timeout, temperature
	assign codes = {q.cfg[sfa_pkg::OT_LSB +: 2], q.cfg[sfa_pkg::PUT_LSB +: 2],
		q.cfg[sfa_pkg::UV_LSB +: 2], q.cfg[sfa_pkg::OVOC_LSB +: 2]};

	// one filter per voltage/current excursion; caller presents the
	// over input as voltage or current per the measurement mode
	sfa_excursion_filter u_filt_over (
		.clock(clock),
		.rst(rst),
		.ms_tick(q.tick),
		.filt_code(q.cfg[sfa_pkg::FILT_LSB +: 2]),
		.excursion(over_excursion),
		.declared(ovoc_decl)
	);
	sfa_excursion_filter u_filt_over_warn (
		.clock(clock),
		.rst(rst),
		.ms_tick(q.tick),
		.filt_code(q.cfg[sfa_pkg::FILT_LSB +: 2]),
		.excursion(over_warn_excursion),
		.declared(ovoc_warn_decl)
	);
	sfa_excursion_filter u_filt_under (
		.clock(clock),
		.rst(rst),
		.ms_tick(q.tick),
		.filt_code(q.cfg[sfa_pkg::FILT_LSB +: 2]),
		.excursion(under_excursion),
		.declared(uv_decl)
	);
	sfa_excursion_filter u_filt_under_warn (
		.clock(clock),
		.rst(rst),
		.ms_tick(q.tick),
		.filt_code(q.cfg[sfa_pkg::FILT_LSB +: 2]),
		.excursion(under_warn_excursion),
		.declared(uv_warn_decl)
	);

	// temperature and timeout go straight through, unfiltered
	assign ot_now = |(temp_fault & temp_sensor_en);
	always_comb begin
		present = '0;
		present[sfa_pkg::EV_OVOC] = ovoc_decl;
		present[sfa_pkg::EV_UV] = uv_decl;
		present[sfa_pkg::EV_PUT] = powerup_timeout;
		present[sfa_pkg::EV_OT] = ot_now;
	end

	// codes disregarded by mode or page act as if nothing happened
	always_comb begin
		ignored = '0;
		ignored[sfa_pkg::EV_UV] = measure_current;
		ignored[sfa_pkg::EV_PUT] = measure_current || (PAGE >= sfa_pkg::HIGH_PAGE_FIRST);
	end

	// faults whose code takes the supply down
	always_comb begin
		acting = '0;
		for (int i = 0; i < sfa_pkg::NUM_EV; i++) begin
			acting[i] = present[i] && !ignored[i]
				&& (codes[2*i +: 2] == sfa_pkg::ACT_LATCH
				|| codes[2*i +: 2] == sfa_pkg::ACT_RETRY);
		end
	end

	// only shared-scope channels obey the lines; pins are active low
	assign line_hold = global_scope && |(obeyed & ~q.line_s2);

	always_comb begin
		d = q;
		d.log_req = 1'b0;
		d.log_kind = '0;
		// register write; reserved positions never store
		if (cfg_wr && cfg_cmd == sfa_pkg::CFG_OFFSET) begin
			d.cfg = cfg_wr_data & sfa_pkg::CFG_WMASK;
		end
		// pin synchroniser, second stage is the only reader of the first
		d.line_s1 = shared_fault_line_in;
		d.line_s2 = q.line_s1;
		// millisecond enable
		d.tick = 1'b0;
		if (q.div >= 32'(MS_CYCLES - 1)) begin
			d.div = '0;
			d.tick = 1'b1;
		end else begin
			d.div = q.div + 32'h1;
		end
		d.prev = present;
		d.master_prev = master_on;
		// clear first so that a same-cycle new fault wins
		if (clear_faults) begin
			d.status = '0;
			d.logged = '0;
			d.alert = 1'b0;
		end
		// new fault events
		for (int i = 0; i < sfa_pkg::NUM_EV; i++) begin
			if (present[i] && !q.prev[i] && !ignored[i]) begin
				d.status[i] = 1'b1;
				if (!q.status[i] && alert_en) begin
					d.alert = 1'b1;
				end
				// code 00 never logs; repeats wait for a clear
				if (codes[2*i +: 2] != sfa_pkg::ACT_NONE && q.cfg[sfa_pkg::LOG_BIT]
					&& !q.logged[i]) begin
					d.log_req = 1'b1;
					d.log_kind[i] = 1'b1;
					d.logged[i] = 1'b1;
				end
				case (codes[2*i +: 2])
					sfa_pkg::ACT_LATCH: begin
						d.state = sfa_pkg::SFA_LATCH;
						if (global_scope) begin
							d.drive = d.drive | permit;
						end
					end
					sfa_pkg::ACT_RETRY: begin
						if (d.state != sfa_pkg::SFA_LATCH) begin
							d.state = sfa_pkg::SFA_RETRY;
							d.retry_cnt = '0;
						end
						if (global_scope) begin
							d.drive = d.drive | permit;
						end
					end
					default: begin
						// 00 and 11 keep running
					end
				endcase
			end
		end
		// retry wait and release
		case (q.state)
			sfa_pkg::SFA_RUN: begin
			end
			sfa_pkg::SFA_RETRY: begin
				if (d.state == sfa_pkg::SFA_RETRY && q.tick && q.retry_cnt != 16'hffff) begin
					d.retry_cnt = q.retry_cnt + 16'h1;
				end
				// undervoltage is left out of the fault-free test
				if (d.state == sfa_pkg::SFA_RETRY && q.retry_cnt >= restart_delay_ms
					&& !(acting[sfa_pkg::EV_OVOC] || acting[sfa_pkg::EV_PUT]
					|| acting[sfa_pkg::EV_OT])) begin
					d.state = sfa_pkg::SFA_RUN;
					d.drive = '0;
				end
			end
			sfa_pkg::SFA_LATCH: begin
			end
			default: begin
				d.state = sfa_pkg::SFA_RUN;
			end
		endcase
		// master power off ends a latch or a pending retry
		if (!master_on && q.master_prev) begin
			d.state = sfa_pkg::SFA_RUN;
			d.drive = '0;
		end
		// mask with the word as it will stand, so a rewrite that drops a
		// permit or leaves shared scope lets go of the line on that edge
		d.drive = d.drive & d.cfg[sfa_pkg::DRIVE_LSB +: 3]
			& {3{d.cfg[sfa_pkg::SCOPE_BIT]}};
		d.supply_en = master_on && d.state == sfa_pkg::SFA_RUN && !line_hold
			&& !(|acting);
		// alarm source select, codes 3, 5 and 7 include warnings
		case (q.cfg[sfa_pkg::ALARM_LSB +: 3])
			3'h1: d.alarm = q.status[sfa_pkg::EV_PUT];
			3'h2: d.alarm = uv_decl;
			3'h3: d.alarm = uv_decl || uv_warn_decl;
			3'h4: d.alarm = ovoc_decl;
			3'h5: d.alarm = ovoc_decl || ovoc_warn_decl;
			3'h6: d.alarm = uv_decl || ovoc_decl;
			3'h7: d.alarm = uv_decl || ovoc_decl || uv_warn_decl || ovoc_warn_decl;
			default: d.alarm = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
			q.cfg <= sfa_pkg::CFG_RESET;
			q.line_s1 <= 3'h7;
			q.line_s2 <= 3'h7;
			q.state <= sfa_pkg::SFA_RUN;
		end else begin
			q <= d;
		end
	end

	// outputs; pins only ever pull low
	assign cfg_rd_data = q.cfg;
	assign shared_fault_line_out = 3'h0;
	assign shared_fault_line_oe = q.drive;
	assign supply_enable_out = q.supply_en;
	assign fault_status = q.status;
	assign alert_out = q.alert;
	assign log_req = q.log_req;
	assign log_kind = q.log_kind;
	assign alarm_out = q.alarm;

	a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
		(cfg_rd_data & ~sfa_pkg::CFG_WMASK) == 32'h0000_0000)
		else $error("reserved bits read nonzero");
	a_obey_hold: assert property (@(posedge clock) disable iff (rst)
		global_scope && |(obeyed & ~q.line_s2) |=> !supply_enable_out)
		else $error("supply on while obeyed line asserted");
	a_drive_permit: assert property (@(posedge clock) disable iff (rst)
		(shared_fault_line_oe & ~permit) == 3'h0 && (global_scope || shared_fault_line_oe == 3'h0))
		else $error("driving a forbidden line");
	a_status_sticky: assert property (@(posedge clock) disable iff (rst)
		fault_status[sfa_pkg::EV_OVOC] && !clear_faults |=> fault_status[sfa_pkg::EV_OVOC])
		else $error("status bit dropped");
	a_temp_or: assert property (@(posedge clock) disable iff (rst)
		$rose(ot_now) |=> fault_status[sfa_pkg::EV_OT])
		else $error("temperature fault missed");
	a_log_gate: assert property (@(posedge clock) disable iff (rst)
		log_req |-> $past(q.cfg[sfa_pkg::LOG_BIT]))
		else $error("logged with logging off");
	a_none_no_log: assert property (@(posedge clock) disable iff (rst)
		log_req && log_kind[sfa_pkg::EV_OVOC] |-> $past(codes[1:0]) != sfa_pkg::ACT_NONE)
		else $error("code 00 logged");
	a_alert_new: assert property (@(posedge clock) disable iff (rst)
		alert_en && $rose(ovoc_decl) && !fault_status[sfa_pkg::EV_OVOC] |=> alert_out)
		else $error("alert missed on new status");
	a_latch_drives: assert property (@(posedge clock) disable iff (rst)
		$rose(ovoc_decl) && codes[1:0] == sfa_pkg::ACT_LATCH && global_scope && master_on
		|=> shared_fault_line_oe == permit && q.state == sfa_pkg::SFA_LATCH)
		else $error("latch off did not drive lines");
	a_retry_off: assert property (@(posedge clock) disable iff (rst)
		q.state == sfa_pkg::SFA_RETRY |-> !supply_enable_out)
		else $error("supply on during retry wait");

	c_retry_release: cover property (@(posedge clock) disable iff (rst)
		q.state == sfa_pkg::SFA_RETRY ##1 q.state == sfa_pkg::SFA_RUN);
	c_latch: cover property (@(posedge clock) disable iff (rst)
		$rose(q.state == sfa_pkg::SFA_LATCH) && shared_fault_line_oe != 3'h0);
	c_obey: cover property (@(posedge clock) disable iff (rst)
		line_hold && master_on);
	c_log: cover property (@(posedge clock) disable iff (rst) log_req);
	c_release_under: cover property (@(posedge clock) disable iff (rst)
		q.state == sfa_pkg::SFA_RETRY && present[sfa_pkg::EV_UV]
		##1 q.state == sfa_pkg::SFA_RUN);
	// a timeout code that does not apply must leave its status bit alone
	a_put_ignored: assert property (@(posedge clock) disable iff (rst)
		ignored[sfa_pkg::EV_PUT] && !fault_status[sfa_pkg::EV_PUT]
		|=> !fault_status[sfa_pkg::EV_PUT])
		else $error("ignored timeout set status");
endmodule : sfa_fault_action
`default_nettype wire

// [bench/sfa_peer_model.sv]
// peer devices sharing the open-drain fault lines, with pull-ups
`timescale 1ns/10ps
`default_nettype none
module sfa_peer_model (
	input wire logic [2:0] dut_oe,
	input wire logic [2:0] dut_out,
	input wire logic [2:0] peer_pull,
	output logic [2:0] line_level
);
	// wired-and of every puller; a released line floats back high
	assign line_level = ~peer_pull & (~dut_oe | dut_out);
endmodule : sfa_peer_model
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the supply fault action block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clock, rst, cfg_wr, measure_current, over_excursion, over_warn_excursion;
	logic under_excursion, under_warn_excursion, powerup_timeout, master_on;
	logic clear_faults, alert_en, supply_enable_out, alert_out, log_req, alarm_out;
	logic [7:0] cfg_cmd;
	logic [31:0] cfg_wr_data, cfg_rd_data;
	logic [4:0] temp_fault, temp_sensor_en;
	logic [15:0] restart_delay_ms;
	logic [2:0] shared_fault_line_in, shared_fault_line_out, shared_fault_line_oe, peer_pull;
	logic [3:0] fault_status, log_kind;
	int n_fail = 0;
	int n_checks = 0;
	int k;
	logic nl;

	// short millisecond so filter and retry counts stay cheap
	sfa_fault_action #(.MS_CYCLES(10)) u_sfa_fault_action (.clock, .rst, .cfg_wr, .cfg_cmd,
		.cfg_wr_data, .cfg_rd_data, .measure_current, .over_excursion, .over_warn_excursion,
		.under_excursion, .under_warn_excursion, .powerup_timeout, .temp_fault,
		.temp_sensor_en, .restart_delay_ms, .master_on, .clear_faults, .alert_en,
		.shared_fault_line_in, .shared_fault_line_out, .shared_fault_line_oe,
		.supply_enable_out, .fault_status, .alert_out, .log_req, .log_kind, .alarm_out);

	sfa_peer_model u_sfa_peer_model (.dut_oe(shared_fault_line_oe),
		.dut_out(shared_fault_line_out), .peer_pull(peer_pull),
		.line_level(shared_fault_line_in));

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	// one-cycle write strobe, launched off the sampling edge
	task wr(input logic [7:0] c, input logic [31:0] d);
		cfg_cmd = c;
		cfg_wr_data = d;
		cfg_wr = 1'b1;
		cyc(1);
		cfg_wr = 1'b0;
		cyc(1);
	endtask : wr

	// bounded wait for a status bit; log pulses seen meanwhile land in nl
	task wst(input int b, input int lim);
		k = 0;
		nl = 1'b0;
		while (fault_status[b] !== 1'b1 && k < lim) begin
			cyc(1);
			nl |= log_req;
			k++;
		end
		if (fault_status[b] !== 1'b1) begin
			chk(fault_status[b], 1'b1);
			complete_run;
		end
	endtask : wst

	// master power off drops latch and retry while status is cleared in the same cycle
	task recover;
		{over_excursion, under_excursion, powerup_timeout} = '0;
		temp_fault = '0;
		master_on = 1'b0;
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(2);
		master_on = 1'b1;
		cyc(3);
	endtask : recover

	task tend(input string s);
		$display("test %s finished", s);
	endtask : tend

	initial begin
		rst = 1'b1;
		{cfg_wr, measure_current, over_excursion, over_warn_excursion} = '0;
		{under_excursion, under_warn_excursion, powerup_timeout, master_on} = '0;
		{clear_faults, alert_en, cfg_cmd, cfg_wr_data} = '0;
		{temp_fault, temp_sensor_en, restart_delay_ms, peer_pull} = '0;
		cyc(5);
		rst = 1'b0;
		// reserved bits and a foreign command code
		chk(cfg_rd_data, 32'h0000_0000);
		wr(8'hd9, 32'hffff_ffff);
		chk(cfg_rd_data, 32'h0707_f7ff);
		wr(8'hd8, 32'h0000_0000);
		chk(cfg_rd_data, 32'h0707_f7ff);
		tend("register");
		// shared latch off on overvoltage, lines 2 and 0 permitted
		alert_en = 1'b1;
		master_on = 1'b1;
		wr(8'hd9, 32'h0005_c001);
		cyc(3);
		chk(supply_enable_out, 1'b1);
		over_excursion = 1'b1;
		wst(0, 6);
		chk({log_req, log_kind}, 5'h11);
		chk({shared_fault_line_out, shared_fault_line_oe}, 6'h05);
		chk(alert_out, 1'b1);
		cyc(1);
		chk(supply_enable_out, 1'b0);
		over_excursion = 1'b0;
		cyc(4);
		chk({fault_status, shared_fault_line_oe}, 7'h0d);
		recover;
		chk({alert_out, fault_status, shared_fault_line_oe}, 8'h00);
		tend("latch");
		// local scope: permits set but no line may be pulled, no log
		wr(8'hd9, 32'h0007_0001);
		over_excursion = 1'b1;
		wst(0, 6);
		cyc(2);
		chk(shared_fault_line_oe, 3'h0);
		chk(supply_enable_out, 1'b0);
		chk(nl, 1'b0);
		recover;
		// action 00 with logging on: status only
		wr(8'hd9, 32'h0007_c000);
		over_excursion = 1'b1;
		wst(0, 6);
		cyc(2);
		chk({nl, log_req, shared_fault_line_oe, supply_enable_out}, 6'h01);
		recover;
		tend("scope");
		// temperature: enabled sensors only, unfiltered, code 11 runs on
		wr(8'hd9, 32'h0007_f0c0);
		temp_sensor_en = 5'h04;
		temp_fault = 5'h01;
		cyc(5);
		chk(fault_status, 4'h0);
		temp_fault = 5'h05;
		wst(3, 4);
		chk({log_req, log_kind}, 5'h18);
		cyc(2);
		chk({shared_fault_line_oe, supply_enable_out}, 4'h1);
		recover;
		tend("temperature");
		// 4 ms filter: a one-cycle break restarts the count
		wr(8'hd9, 32'h0000_3003);
		over_excursion = 1'b1;
		cyc(18);
		over_excursion = 1'b0;
		cyc(1);
		over_excursion = 1'b1;
		cyc(25);
		chk(fault_status, 4'h0);
		wst(0, 20);
		recover;
		tend("filter");
		// retry with a standing undervoltage, itself set to retry, still releases
		restart_delay_ms = 16'h0002;
		wr(8'hd9, 32'h0002_400a);
		under_excursion = 1'b1;
		over_excursion = 1'b1;
		wst(0, 6);
		over_excursion = 1'b0;
		cyc(1);
		chk(shared_fault_line_oe, 3'h2);
		cyc(6);
		chk(shared_fault_line_oe, 3'h2);
		k = 0;
		while (shared_fault_line_oe !== 3'h0 && k < 30) begin
			cyc(1);
			k++;
		end
		chk(shared_fault_line_oe, 3'h0);
		if (k >= 30) begin
			complete_run;
		end
		recover;
		tend("retry");
		// obey line 1 only while peers pull lines
		wr(8'hd9, 32'h0200_4000);
		peer_pull = 3'h1;
		cyc(5);
		chk(supply_enable_out, 1'b1);
		peer_pull = 3'h2;
		cyc(4);
		chk(supply_enable_out, 1'b0);
		peer_pull = 3'h0;
		cyc(6);
		chk(supply_enable_out, 1'b1);
		tend("obey");
		// current channel in shared scope ignores under and timeout codes
		measure_current = 1'b1;
		wr(8'hd9, 32'h0000_4015);
		under_excursion = 1'b1;
		powerup_timeout = 1'b1;
		cyc(6);
		chk(fault_status, 4'h0);
		over_excursion = 1'b1;
		wst(0, 6);
		recover;
		measure_current = 1'b0;
		tend("current");
		// alarm source table: under warn, over warn, under fault, over fault
		for (int w = 0; w < 4; w++) begin
			{over_excursion, under_excursion, over_warn_excursion, under_warn_excursion} = 4'h1 << w;
			for (int c = 0; c < 8; c++) begin
				wr(8'hd9, 32'(c) << 8);
				cyc(1);
				chk(alarm_out, (w > 1 || c[0]) && (w[0] ? c[2] : c[1]));
			end
		end
		tend("alarm");
		complete_run;
	end
endmodule : tb_top
`default_nettype wire
